// File: design/apsf_pkg.sv
// constants shared by the audio port sync and flag pin logic
package apsf_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_COMMON_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX_CLK_CTRL = 8'h04;
	localparam logic [7:0] OFS_RX_CLK_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS      = 8'h0C;
	localparam logic [7:0] OFS_GPIO_CFG    = 8'h10;
	// audio_common_control_reg field positions
	localparam int CTL_SYN  = 0;
	localparam int CTL_NET  = 1;
	localparam int CTL_OF0  = 2;
	localparam int CTL_PORT = 3;
	localparam logic [3:0] CTL_RESET = 4'h0;
	// tx / rx clock control field positions
	localparam int TCC_TX_FRAMESYNC_DIRECTION = 0;
	localparam int RCC_RX_CLOCK_DIRECTION = 0;
	// audio_status_reg field positions
	localparam int STA_IF0 = 0;
	localparam int STA_GIN0 = 1;
	localparam int STA_GIN4 = 2;
	// gpio config: mode fields and output data bits
	localparam int GC_MODE0 = 0;
	localparam int GC_MODE4 = 2;
	localparam int GC_DATA0 = 4;
	localparam int GC_DATA4 = 5;
	localparam logic [5:0] GC_RESET = 6'h00;
	// per-line gpio modes
	localparam logic [1:0] GM_OFF = 2'h0;
	localparam logic [1:0] GM_IN  = 2'h1;
	localparam logic [1:0] GM_OUT = 2'h2;
	// configuration word carried into the link domain
	localparam int CF_PORT = 0;
	localparam int CF_SYN  = 1;
	localparam int CF_NET  = 2;
	localparam int CF_OF0  = 3;
	localparam int CF_TX_FRAMESYNC_DIRECTION = 4;
	localparam int CF_RX_CLOCK_DIRECTION = 5;
	localparam int CF_GC   = 6;
	localparam int CF_W    = 12;
	// frame shape: last link clock cycle of a slot, last slot of a frame
	localparam logic [4:0] SLOT_LAST  = 5'h1F;
	localparam logic [1:0] FRAME_LAST = 2'h3;
endpackage

// File: design/apsf_top.sv
// sync and flag pin logic of the second audio serial port
// Notes on behaviour
// - sync mode: tx frame sync frames everything
// - async mode: tx frame sync for transmitters
// - tx frame sync direction from tx_framesync_direction bit
// - gpio mode: lines in, out or off
// - after reset all pins disconnected
// - async mode: rx clock line is bit clock
// - sync mode: rx clock line is flag
// - flag direction follows rx clock direction bit
// - output flag shows output_flag_zero bit
// - flag out updates at frame or slot
// - flag in captured at frame or slot
// - sync mode: tx bit clock clocks receivers
module apsf_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        port_line_zero_in,
	output logic             port_line_zero_out,
	output logic             port_line_zero_oe_n,
	input  wire logic        port_line_four_in,
	output logic             port_line_four_out,
	output logic             port_line_four_oe_n,
	output logic             tx_frame_start,
	output logic             rx_frame_start,
	output logic             rx_framing_from_tx,
	output logic             rx_clock_from_tx
);

	// register-side state, all in the pclk domain
	typedef struct packed {
		logic [3:0]  ctl;
		logic        tx_framesync_direction;
		logic        rx_clock_direction;
		logic [5:0]  gcfg;
		logic [1:0]  gin_s1;
		logic [1:0]  gin_s2;
		logic        if0_s1;
		logic        if0_s2;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        rx_fs_tx;
		logic        rx_ck_tx;
	} apsf_p_t;

	// link-side state
	typedef struct packed {
		logic [11:0] cfg_s1;
		logic [11:0] cfg_s2;
		logic [1:0]  pin_s1;
		logic [1:0]  pin_s2;
		logic        fs_prev;
		logic [4:0]  bit_cnt;
		logic [1:0]  slot_cnt;
		logic        flag;
		logic        if0;
		logic        ck;
		logic        l0_out;
		logic        l0_oen;
		logic        l4_out;
		logic        l4_oen;
		logic        tx_fs;
		logic        rx_fs;
	} apsf_l_t;

	apsf_p_t p_r;
	apsf_p_t p_nxt;
	apsf_l_t l_r;
	apsf_l_t l_nxt;

	logic [apsf_pkg::CF_W-1:0] cfg_word;
	logic                      acc_done;
	logic                      addr_ok;
	logic [31:0]               rd_val;

	// configuration levels handed to the link side
	assign cfg_word = {p_r.gcfg, p_r.rx_clock_direction, p_r.tx_framesync_direction,
		p_r.ctl[apsf_pkg::CTL_OF0], p_r.ctl[apsf_pkg::CTL_NET],
		p_r.ctl[apsf_pkg::CTL_SYN], p_r.ctl[apsf_pkg::CTL_PORT]};

	// apb transfer completes on the edge that sees pready high
	assign acc_done = psel & penable & p_r.pready;

	// register read mux, unmapped addresses flagged
	always_comb begin
		rd_val = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
		apsf_pkg::OFS_COMMON_CTRL: begin
			rd_val[3:0] = p_r.ctl;
		end
		apsf_pkg::OFS_TX_CLK_CTRL: begin
			rd_val[apsf_pkg::TCC_TX_FRAMESYNC_DIRECTION] = p_r.tx_framesync_direction;
		end
		apsf_pkg::OFS_RX_CLK_CTRL: begin
			rd_val[apsf_pkg::RCC_RX_CLOCK_DIRECTION] = p_r.rx_clock_direction;
		end
		apsf_pkg::OFS_STATUS: begin
			rd_val[apsf_pkg::STA_IF0] = p_r.if0_s2;
			rd_val[apsf_pkg::STA_GIN0] = p_r.gin_s2[0];
			rd_val[apsf_pkg::STA_GIN4] = p_r.gin_s2[1];
		end
		apsf_pkg::OFS_GPIO_CFG: begin
			rd_val[5:0] = p_r.gcfg;
		end
		default: begin
			addr_ok = 1'b0;
		end
		endcase
	end

	// register side next state
	always_comb begin
		p_nxt = p_r;
		// one wait state, then the answer
		p_nxt.pready = psel & penable & ~p_r.pready;
		p_nxt.pslverr = psel & penable & ~p_r.pready & ~addr_ok;
		p_nxt.prdata = (psel & penable & ~p_r.pready & ~pwrite)
			? rd_val : 32'h0000_0000;
		if (acc_done & pwrite) begin
			case (paddr)
			apsf_pkg::OFS_COMMON_CTRL: p_nxt.ctl = pwdata[3:0];
			apsf_pkg::OFS_TX_CLK_CTRL: begin
				p_nxt.tx_framesync_direction = pwdata[apsf_pkg::TCC_TX_FRAMESYNC_DIRECTION];
			end
			apsf_pkg::OFS_RX_CLK_CTRL: begin
				p_nxt.rx_clock_direction = pwdata[apsf_pkg::RCC_RX_CLOCK_DIRECTION];
			end
			apsf_pkg::OFS_GPIO_CFG: p_nxt.gcfg = pwdata[5:0];
			default: p_nxt.gcfg = p_r.gcfg;
			endcase
		end
		// pins pass two flops before anything reads them
		p_nxt.gin_s1 = {port_line_four_in, port_line_zero_in};
		p_nxt.if0_s1 = l_r.if0;
		p_nxt.if0_s2 = p_r.if0_s1;
		// gpio input seen only in input mode
		p_nxt.gin_s2[0] = p_r.gin_s1[0] & ~p_r.ctl[apsf_pkg::CTL_PORT]
			& (p_r.gcfg[apsf_pkg::GC_MODE0 +: 2] == apsf_pkg::GM_IN);
		p_nxt.gin_s2[1] = p_r.gin_s1[1] & ~p_r.ctl[apsf_pkg::CTL_PORT]
			& (p_r.gcfg[apsf_pkg::GC_MODE4 +: 2] == apsf_pkg::GM_IN);
		// receivers framed by tx sync in sync mode
		p_nxt.rx_fs_tx = p_r.ctl[apsf_pkg::CTL_PORT]
			& p_r.ctl[apsf_pkg::CTL_SYN];
		// receivers clocked by tx bit clock in sync mode
		p_nxt.rx_ck_tx = p_r.ctl[apsf_pkg::CTL_PORT]
			& p_r.ctl[apsf_pkg::CTL_SYN];
	end

	// register side flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_r <= '0;
			p_r.ctl <= apsf_pkg::CTL_RESET;
			p_r.gcfg <= apsf_pkg::GC_RESET;
		end else begin
			p_r <= p_nxt;
		end
	end

	// link side locals
	logic [apsf_pkg::CF_W-1:0] c;
	logic                      fs_dir_out;
	logic                      fs_rise;
	logic                      frame_st;
	logic                      slot_st;
	logic                      upd;
	logic                      flag_out_mode;
	logic                      flag_in_mode;
	logic [1:0]                mode0;
	logic [1:0]                mode4;

	// link side next state
	always_comb begin
		l_nxt = l_r;
		c = l_r.cfg_s2;
		mode0 = c[apsf_pkg::CF_GC + apsf_pkg::GC_MODE0 +: 2];
		mode4 = c[apsf_pkg::CF_GC + apsf_pkg::GC_MODE4 +: 2];
		l_nxt.cfg_s1 = cfg_word;
		l_nxt.cfg_s2 = l_r.cfg_s1;
		l_nxt.pin_s1 = {port_line_four_in, port_line_zero_in};
		l_nxt.pin_s2 = l_r.pin_s1;
		l_nxt.fs_prev = l_r.pin_s2[1];
		// frame sync driven or sampled per tx_framesync_direction
		fs_dir_out = c[apsf_pkg::CF_TX_FRAMESYNC_DIRECTION];
		fs_rise = l_r.pin_s2[1] & ~l_r.fs_prev;
		// bit and slot counters, resynced by an input sync
		if (!c[apsf_pkg::CF_PORT]) begin
			l_nxt.bit_cnt = 5'h00;
			l_nxt.slot_cnt = 2'h0;
		end else if (!fs_dir_out && fs_rise) begin
			l_nxt.bit_cnt = 5'h01;
			l_nxt.slot_cnt = 2'h0;
		end else if (l_r.bit_cnt == apsf_pkg::SLOT_LAST) begin
			l_nxt.bit_cnt = 5'h00;
			l_nxt.slot_cnt = (l_r.slot_cnt == apsf_pkg::FRAME_LAST)
				? 2'h0 : 2'(l_r.slot_cnt + 2'h1);
		end else begin
			l_nxt.bit_cnt = 5'(l_r.bit_cnt + 5'h01);
		end
		frame_st = c[apsf_pkg::CF_PORT] & (fs_dir_out
			? (l_r.bit_cnt == 5'h00 && l_r.slot_cnt == 2'h0)
			: fs_rise);
		slot_st = c[apsf_pkg::CF_PORT] & (fs_dir_out
			? (l_r.bit_cnt == 5'h00)
			: (fs_rise | (l_r.bit_cnt == 5'h00)));
		upd = c[apsf_pkg::CF_NET] ? slot_st : frame_st;
		flag_out_mode = c[apsf_pkg::CF_PORT] & c[apsf_pkg::CF_SYN]
			& c[apsf_pkg::CF_RX_CLOCK_DIRECTION];
		flag_in_mode = c[apsf_pkg::CF_PORT] & c[apsf_pkg::CF_SYN]
			& ~c[apsf_pkg::CF_RX_CLOCK_DIRECTION];
		if (upd & flag_out_mode) begin
			l_nxt.flag = c[apsf_pkg::CF_OF0];
		end
		// flag pin captured at update point
		if (upd & flag_in_mode) begin
			l_nxt.if0 = l_r.pin_s2[0];
		end
		// bit clock out in async mode
		l_nxt.ck = (c[apsf_pkg::CF_PORT] & ~c[apsf_pkg::CF_SYN]
			& c[apsf_pkg::CF_RX_CLOCK_DIRECTION]) ? ~l_r.ck : 1'b0;
		// transmitters always framed by tx sync
		l_nxt.tx_fs = frame_st;
		// receivers framed by tx sync in sync mode
		l_nxt.rx_fs = frame_st & c[apsf_pkg::CF_SYN];
		if (!c[apsf_pkg::CF_PORT]) begin
			// gpio lines: off, input or output
			l_nxt.l0_oen = (mode0 != apsf_pkg::GM_OUT);
			l_nxt.l0_out = (mode0 == apsf_pkg::GM_OUT)
				& c[apsf_pkg::CF_GC + apsf_pkg::GC_DATA0];
			l_nxt.l4_oen = (mode4 != apsf_pkg::GM_OUT);
			l_nxt.l4_out = (mode4 == apsf_pkg::GM_OUT)
				& c[apsf_pkg::CF_GC + apsf_pkg::GC_DATA4];
		end else begin
			// drive sync pulse when direction is out
			l_nxt.l4_oen = ~fs_dir_out;
			l_nxt.l4_out = fs_dir_out & frame_st;
			l_nxt.l0_oen = ~c[apsf_pkg::CF_RX_CLOCK_DIRECTION];
			// line carries flag in sync mode
			if (c[apsf_pkg::CF_SYN]) begin
				l_nxt.l0_out = flag_out_mode & l_nxt.flag;
			end else begin
				l_nxt.l0_out = l_nxt.ck;
			end
		end
	end

	// link side flops
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			l_r <= '0;
			l_r.l0_oen <= 1'b1;
			l_r.l4_oen <= 1'b1;
		end else begin
			l_r <= l_nxt;
		end
	end

	// outputs straight from flops
	assign prdata = p_r.prdata;
	assign pready = p_r.pready;
	assign pslverr = p_r.pslverr;
	assign port_line_zero_out = l_r.l0_out;
	assign port_line_zero_oe_n = l_r.l0_oen;
	assign port_line_four_out = l_r.l4_out;
	assign port_line_four_oe_n = l_r.l4_oen;
	assign tx_frame_start = l_r.tx_fs;
	assign rx_frame_start = l_r.rx_fs;
	assign rx_framing_from_tx = p_r.rx_fs_tx;
	assign rx_clock_from_tx = p_r.rx_ck_tx;

endmodule

// File: verif/apsf_chk.sv
// assertions on bus and pins of the sync and flag logic
module apsf_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        link_clk,
	input wire logic        port_line_zero_oe_n,
	input wire logic        port_line_four_oe_n,
	input wire logic        tx_frame_start,
	input wire logic        rx_frame_start,
	input wire logic        rx_framing_from_tx,
	input wire logic        rx_clock_from_tx
);
	a_pins_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> port_line_zero_oe_n && port_line_four_oe_n)
		else $error("pin driven right after reset");
	a_ready_wait: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
		else $error("error flag wrong for address");
	a_err_pair: assert property (
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error flag without ready");
	a_rdata_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_frame_both: assert property (
		@(posedge link_clk) disable iff (!presetn)
		rx_frame_start |-> tx_frame_start)
		else $error("receive frame without transmit frame");
	a_frame_gap: assert property (
		@(posedge link_clk) disable iff (!presetn)
		tx_frame_start |=> !tx_frame_start [*8])
		else $error("frame starts too close");
	a_rx_tx_same: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_framing_from_tx == rx_clock_from_tx)
		else $error("receive framing and clock differ");
endmodule

bind apsf_top apsf_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .link_clk, .port_line_zero_oe_n,
	.port_line_four_oe_n, .tx_frame_start, .rx_frame_start,
	.rx_framing_from_tx, .rx_clock_from_tx);

// File: verif/apsf_partner.sv
// codec side of one line, with the pin pull-down
module apsf_partner (
	input wire logic dev_out,
	input wire logic dev_oe_n,
	input wire logic drv_en,
	input wire logic drv_val,
	output logic     line_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// device wins when driving, then codec, else pull-down
	assign line_in = !dev_oe_n ? dev_out : (drv_en ? drv_val : 1'b0);
endmodule

// File: verif/apsf_top_test.sv
// bench for the audio port sync and flag pin logic
module apsf_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, r;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        link_clk, port_line_zero_in, port_line_zero_out;
	logic        port_line_zero_oe_n, port_line_four_in, port_line_four_out;
	logic        port_line_four_oe_n, tx_frame_start, rx_frame_start;
	logic        rx_framing_from_tx, rx_clock_from_tx, z_en, z_val, f_en, f_val;
	int          num_errors, cmp_count, m, v0, v4, d0, d4;
	int          mdl [5] = '{0, 0, 0, 0, 0};
	int          msk [5] = '{32'hF, 1, 1, 0, 32'h3F};

	apsf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link_clk, .port_line_zero_in,
		.port_line_zero_out, .port_line_zero_oe_n, .port_line_four_in,
		.port_line_four_out, .port_line_four_oe_n, .tx_frame_start,
		.rx_frame_start, .rx_framing_from_tx, .rx_clock_from_tx);
	apsf_partner u_p0 (.dev_out(port_line_zero_out), .drv_en(z_en),
		.dev_oe_n(port_line_zero_oe_n), .drv_val(z_val),
		.line_in(port_line_zero_in));
	apsf_partner u_p4 (.dev_out(port_line_four_out), .drv_en(f_en),
		.dev_oe_n(port_line_four_oe_n), .drv_val(f_val),
		.line_in(port_line_four_in));

	// register clock and free-running bit clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			report_and_stop();
		end
	endtask
	// one apb transfer, model updated on writes
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer taken at the very edge that sees pready high
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			r = pready;
			q = prdata;
			e = pslverr;
			if (r === 1'b1)
				break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(n, 20);
		if (w && a <= 8'h10)
			mdl[a >> 2] = d & msk[a >> 2];
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(q, x);
	endtask
	task automatic waitf;
		int n;
		for (n = 0; n < 400; n++) begin
			@(negedge link_clk);
			if (tx_frame_start === 1'b1)
				break;
		end
		tmo(n, 400);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{z_en, z_val, f_en, f_val} = '0;
		num_errors = 0;
		cmp_count = 0;
		m = $urandom(32'h9638);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		check({port_line_four_oe_n, port_line_zero_oe_n}, 3);
		for (int i = 0; i < 5; i++)
			rd(i * 4, mdl[i]);
		apb(1'b0, 8'h20, 32'h0);
		check(q, 32'h0000_0000);
		check({31'h0, e}, 32'h0000_0001);
		for (m = 0; m < 4; m++) begin
			{d0, d4, v0, v4} = {$urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2};
			{z_en, f_en} <= 2'h3;
			z_val <= v0[0];
			f_val <= v4[0];
			apb(1'b1, 8'h10, m | m << 2 | d0 << 4 | d4 << 5);
			repeat (8) @(posedge pclk);
			check({port_line_four_oe_n, port_line_zero_oe_n}, m == 2 ? 0 : 3);
			if (m == 2)
				check({port_line_four_out, port_line_zero_out}, d4 * 2 + d0);
			rd(8'h0C, m == 1 ? v0 * 2 + v4 * 4 : 0);
		end
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b1, 8'h00, 32'h5);
		apb(1'b1, 8'h00, 32'hD);
		waitf();
		check(rx_frame_start, 1);
		repeat (3) @(negedge link_clk);
		// pclk-side levels settle one pclk after the write
		check(rx_framing_from_tx, 1);
		check(rx_clock_from_tx, 1);
		check(port_line_four_oe_n, 0);
		check({port_line_zero_oe_n, port_line_zero_out}, 1);
		// flag waits for frame, then slot
		apb(1'b1, 8'h00, 32'h9);
		check(port_line_zero_out, 1);
		waitf();
		repeat (3) @(negedge link_clk);
		check(port_line_zero_out, 0);
		apb(1'b1, 8'h00, 32'hF);
		repeat (60) @(negedge link_clk);
		check(port_line_zero_out, 1);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h9);
		v0 = $urandom % 2;
		z_val <= v0[0];
		waitf();
		waitf();
		check(port_line_zero_oe_n, 1);
		apb(1'b0, 8'h0C, 32'h0);
		check(q[0], v0[0]);
		waitf();
		@(posedge pclk);
		z_val <= ~v0[0];
		apb(1'b0, 8'h0C, 32'h0);
		check(q[0], v0[0]);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h8);
		repeat (4) @(posedge pclk);
		check(rx_framing_from_tx, 0);
		check(rx_clock_from_tx, 0);
		waitf();
		check(rx_frame_start, 0);
		// input frame sync: the codec's rising edge starts a frame
		f_val <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h8);
		repeat (4) @(posedge pclk);
		f_val <= 1'b1;
		waitf();
		check(port_line_four_oe_n, 1);
		// register readback against the model
		for (int i = 0; i < 5; i++)
			if (i != 3)
				rd(i * 4, mdl[i]);
		report_and_stop();
	end
endmodule
